// >>> design/spc_unit.sv
// Module: SPI unit with AXI4-Lite register slave, double buffers and shifter
//
// Contract
// RULE_01 - Software writes control one, then control two, then bit rate when master.
// RULE_02 - Control one bit 7 masks receive-full and fault interrupts; 0 suppresses.
// RULE_03 - Control one bit 6 set enables the whole serial system.
// RULE_04 - Control one bit 5 lets transmit-empty flag request an interrupt.
// RULE_05 - Control one bit 4: 1 master role, 0 slave role.
// RULE_06 - Control one bit 3 sets clock polarity; 0 idles low.
// RULE_07 - Control one bit 2 phase; 1 puts first edge at bit start.
// RULE_08 - Control one bit 1 picks select pin as auto output or fault input.
// RULE_09 - Control one bit 0 bit order; 0 MSB first, 1 LSB first.
// RULE_10 - Control two bits 7:5, 2 unimplemented; bit 4 enables fault detection.
// RULE_11 - Control two bit 3 drives shared data pin; 0 makes it input.
// RULE_12 - Control two bit 1 stops serial clocks in wait; 0 keeps running.
// RULE_13 - Control two bit 0: 0 separate pins, 1 shared bidirectional pin.
// RULE_14 - Bit rate holds prescale 6:4, divisor 2:0; code 000 gives 1 and 2.
// RULE_15 - Fastest master serial clock is bus clock divided by two.
// RULE_16 - Status bit 7 set when receive buffer holds a complete byte.
// RULE_17 - Status bit 5 set when transmit buffer is empty.
// RULE_18 - Status bit 4 is master fault flag; bits 6, 3:0 unimplemented.
// RULE_19 - Data address: writes load transmit buffer, reads return receive buffer.
// RULE_20 - Interrupt request when any flag is set with its mask set; the transmit-empty request also needs the system enabled.
// RULE_21 - Fault sets flag, clears master select, disables clock and data drivers.
// RULE_22 - Fault flag clears after status read while set, then control one write.
// RULE_23 - Data write while empty loads buffer and clears empty flag until moved.
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`default_nettype none
module spc_unit (
  input  wire logic                     mclk,
  input  wire logic                     nrst,
  input  wire logic                     clkEn,
  input  wire logic                     cpuWait,
  input  wire logic [7:0]               awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [7:0]               araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  input  wire spc_pkg::spc_pin_in_type  pinIn,
  output spc_pkg::spc_pin_out_type      pinOut,
  output logic                          irqReq
);
  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    logic [7:0]             ctl1;
    logic [7:0]             ctl2;
    logic [7:0]             rate;
    logic                   waitCtl;
    logic                   rxFull;
    logic                   txEmpty;
    logic                   fault;
    logic                   faultSeen;
    logic [7:0]             txBuf;
    logic [7:0]             rxBuf;
    logic [7:0]             shift;
    logic [3:0]             edges;
    logic [10:0]            divCnt;
    logic                   sck;
    logic                   sckPrev;
    logic                   selPrev;
    spc_pkg::spc_state_type st;
    logic                   awHeld;
    logic [7:0]             awAddr;
    logic                   wHeld;
    logic [7:0]             wByte;
    logic                   wLane;
    logic                   bv;
    logic [1:0]             br;
    logic                   rv;
    logic [31:0]            rd;
    logic [1:0]             rr;
    logic                   dataOut;
  } spc_regs_type;

  spc_regs_type r_q;
  spc_regs_type r_d;

  // Half period in bus clocks: prescale times divisor/2
  function automatic logic [10:0] halfPeriod(input logic [7:0] rate);
    logic [10:0] pre;
    logic [10:0] div;
    pre = {8'h00, rate[6:4]} + 11'h001;                       // RULE_14
    div = 11'h001 << rate[2:0];                               // RULE_14 RULE_15
    halfPeriod = 11'(pre * div);
  endfunction

  // Register address match on the word
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  logic       enabled;
  logic       master;
  logic       clock_polarity;
  logic       clock_phase;
  logic       lsbFirst;
  logic       faultIn;
  logic       autoSel;
  logic       single;
  logic       sampleIn;
  logic       selLow;
  logic       pinEdge;
  logic       lead;
  logic [7:0] readByte;

  assign enabled  = r_q.ctl1[spc_pkg::SYSTEM_ENABLE_BIT];      // RULE_03
  assign master   = r_q.ctl1[spc_pkg::MASTER_SELECT_BIT];      // RULE_05
  assign clock_polarity     = r_q.ctl1[spc_pkg::CLOCK_POLARITY_BIT];
  assign clock_phase     = r_q.ctl1[spc_pkg::CLOCK_PHASE_BIT];
  assign lsbFirst = r_q.ctl1[spc_pkg::LOW_BIT_FIRST_BIT];
  assign single   = r_q.ctl2[spc_pkg::SINGLE_WIRE_SEL_BIT];    // RULE_13
  // Select pin is a fault input as master, detect on, auto-select off
  assign faultIn  = master && r_q.ctl2[spc_pkg::FAULT_DETECT_EN_BIT]
                    && !r_q.ctl1[spc_pkg::SELECT_OUTPUT_EN_BIT];       // RULE_08 RULE_10
  assign autoSel  = master && r_q.ctl2[spc_pkg::FAULT_DETECT_EN_BIT]
                    && r_q.ctl1[spc_pkg::SELECT_OUTPUT_EN_BIT];        // RULE_08
  // Shared pin: master uses MOSI wire, slave uses MISO wire
  assign sampleIn = master ? (single ? pinIn.mosiIn : pinIn.misoIn)
                           : (single ? pinIn.misoIn : pinIn.mosiIn);   // RULE_13
  assign selLow   = !pinIn.selIn;
  // Slave clock edge seen on the pin, polarity removed
  assign pinEdge  = (pinIn.clkIn ^ clock_polarity) != r_q.sckPrev;                // RULE_06
  // Leading edges are the odd ones counted from one
  assign lead     = !r_q.edges[0];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic       doEdge;
    r_d      = r_q;
    doEdge   = 1'b0;
    readByte = 8'h00;
    r_d.sckPrev = pinIn.clkIn ^ clock_polarity;
    r_d.selPrev = selLow;

    // Bus write channels may arrive in either order
    if (awvalid && awready) begin
      r_d.awHeld = 1'b1;
      r_d.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      r_d.wHeld = 1'b1;
      r_d.wByte = wdata[7:0];
      r_d.wLane = wstrb[0];
    end
    if (bvalid && bready) begin
      r_d.bv = 1'b0;
    end
    if (rvalid && rready) begin
      r_d.rv = 1'b0;
    end

    // Write execute once both halves are held
    if (r_q.awHeld && r_q.wHeld && !r_q.bv) begin
      r_d.awHeld = 1'b0;
      r_d.wHeld  = 1'b0;
      r_d.bv     = 1'b1;
      r_d.br     = spc_pkg::RESP_OKAY;
      if (hit(r_q.awAddr, spc_pkg::OFF_CONTROL_ONE)) begin
        if (r_q.wLane) begin
          r_d.ctl1 = r_q.wByte;
        end
        // Clear completes only after a status read saw the flag
        if (r_q.faultSeen) begin
          r_d.fault     = 1'b0;                                 // RULE_22
          r_d.faultSeen = 1'b0;
        end
      end else if (hit(r_q.awAddr, spc_pkg::OFF_CONTROL_TWO)) begin
        if (r_q.wLane) begin
          r_d.ctl2 = r_q.wByte & spc_pkg::CONTROL_TWO_MASK;     // RULE_10
        end
      end else if (hit(r_q.awAddr, spc_pkg::OFF_BIT_RATE_DIVIDER)) begin
        if (r_q.wLane) begin
          r_d.rate = r_q.wByte & spc_pkg::BIT_RATE_MASK;        // RULE_14
        end
      end else if (hit(r_q.awAddr, spc_pkg::OFF_SHIFT_DATA)) begin
        // A write while full is dropped; software polls the flag first
        if (r_q.wLane && r_q.txEmpty) begin
          r_d.txBuf   = r_q.wByte;                              // RULE_19
          r_d.txEmpty = 1'b0;                                   // RULE_23
        end
      end else if (hit(r_q.awAddr, spc_pkg::OFF_WAIT_CTRL)) begin
        if (r_q.wLane) begin
          r_d.waitCtl = r_q.wByte[0];
        end
      end else if (!hit(r_q.awAddr, spc_pkg::OFF_FLAG_STATUS)) begin
        r_d.br = spc_pkg::RESP_SLVERR;
      end
    end

    // Read path; data read pops the receive buffer
    if (arvalid && arready) begin
      r_d.rv = 1'b1;
      r_d.rr = spc_pkg::RESP_OKAY;
      if (hit(araddr, spc_pkg::OFF_CONTROL_ONE)) begin
        readByte = r_q.ctl1;
      end else if (hit(araddr, spc_pkg::OFF_CONTROL_TWO)) begin
        readByte = r_q.ctl2;
      end else if (hit(araddr, spc_pkg::OFF_BIT_RATE_DIVIDER)) begin
        readByte = r_q.rate;
      end else if (hit(araddr, spc_pkg::OFF_FLAG_STATUS)) begin
        readByte[spc_pkg::RX_FULL_FLAG_BIT]  = r_q.rxFull;      // RULE_16 RULE_18
        readByte[spc_pkg::TX_EMPTY_FLAG_BIT] = r_q.txEmpty;     // RULE_17
        readByte[spc_pkg::FAULT_FLAG_BIT]    = r_q.fault;
        if (r_q.fault) begin
          r_d.faultSeen = 1'b1;                                 // RULE_22
        end
      end else if (hit(araddr, spc_pkg::OFF_SHIFT_DATA)) begin
        readByte   = r_q.rxBuf;                                 // RULE_19
        r_d.rxFull = 1'b0;
      end else if (hit(araddr, spc_pkg::OFF_WAIT_CTRL)) begin
        readByte[0] = r_q.waitCtl;
      end else begin
        r_d.rr = spc_pkg::RESP_SLVERR;
      end
      r_d.rd = {24'h000000, readByte};
    end

    // ****************************************************************
    // Transfer engine
    // ****************************************************************
    if (!enabled) begin
      r_d.st      = spc_pkg::ST_IDLE;
      r_d.sck     = 1'b0;
      r_d.txEmpty = 1'b1;
      r_d.rxFull  = 1'b0;
    end else if (faultIn && selLow) begin
      // Another master is driving us: back off at once
      r_d.fault = 1'b1;                                         // RULE_21
      r_d.ctl1[spc_pkg::MASTER_SELECT_BIT] = 1'b0;              // RULE_21
      r_d.st    = spc_pkg::ST_IDLE;
      r_d.sck   = 1'b0;
    end else if (master) begin
      // Clocks freeze in wait only when asked to
      if (!(cpuWait && r_q.ctl2[spc_pkg::WAIT_CLOCK_STOP_BIT])) begin   // RULE_12
        case (r_q.st)
          spc_pkg::ST_IDLE: begin
            if (!r_q.txEmpty) begin
              r_d.shift   = r_q.txBuf;
              r_d.txEmpty = 1'b1;                               // RULE_23
              r_d.edges   = 4'h0;
              r_d.divCnt  = halfPeriod(r_q.rate);
              r_d.st      = spc_pkg::ST_LEAD;
              r_d.dataOut = lsbFirst ? r_q.txBuf[0] : r_q.txBuf[7];  // RULE_09
            end
          end
          spc_pkg::ST_LEAD, spc_pkg::ST_RUN, spc_pkg::ST_TRAIL: begin
            if (r_q.divCnt > 11'h001) begin
              r_d.divCnt = r_q.divCnt - 11'h001;
            end else begin
              r_d.divCnt = halfPeriod(r_q.rate);
              if (r_q.st == spc_pkg::ST_LEAD) begin
                r_d.st = spc_pkg::ST_RUN;
              end else if (r_q.st == spc_pkg::ST_TRAIL) begin
                r_d.st = spc_pkg::ST_IDLE;
              end else begin
                doEdge    = 1'b1;
                r_d.sck   = !r_q.sck;
                r_d.edges = r_q.edges + 4'h1;
                if (r_q.edges == 4'(2 * spc_pkg::BITS_PER_BYTE - 1)) begin
                  r_d.st = spc_pkg::ST_TRAIL;
                end
              end
            end
          end
          default: begin
            r_d.st = spc_pkg::ST_IDLE;
          end
        endcase
      end
    end else begin
      // Slave: edges come from the pin while selected
      if (selLow && !r_q.selPrev) begin
        r_d.shift   = r_q.txBuf;
        r_d.txEmpty = 1'b1;
        r_d.edges   = 4'h0;
        r_d.dataOut = lsbFirst ? r_q.txBuf[0] : r_q.txBuf[7];
      end else if (selLow && pinEdge) begin
        doEdge    = 1'b1;
        r_d.edges = r_q.edges + 4'h1;
      end
    end

    // Sample on the data-valid edge, shift on the other
    if (doEdge) begin
      if (lead ^ clock_phase) begin                                    // RULE_07
        if (lsbFirst) begin
          r_d.shift = {sampleIn, r_q.shift[7:1]};               // RULE_09
        end else begin
          r_d.shift = {r_q.shift[6:0], sampleIn};
        end
        if (r_q.edges == 4'(2 * spc_pkg::BITS_PER_BYTE - 1) - 4'(!clock_phase)) begin
          // Overrun keeps the older byte
          if (!r_q.rxFull) begin
            r_d.rxBuf  = r_d.shift;
            r_d.rxFull = 1'b1;                                  // RULE_16
          end
        end
      end else begin
        r_d.dataOut = lsbFirst ? r_q.shift[0] : r_q.shift[7];
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_q         <= '0;
      r_q.ctl1    <= spc_pkg::CONTROL_ONE_RST;
      r_q.ctl2    <= spc_pkg::CONTROL_TWO_RST;
      r_q.rate    <= spc_pkg::BIT_RATE_RST;
      r_q.txEmpty <= 1'b1;
      r_q.st      <= spc_pkg::ST_IDLE;
    end else if (clkEn) begin
      r_q <= r_d;
    end
  end

  // ****************************************************************
  // Bus handshakes and outputs
  // ****************************************************************
  // One write and one read at a time keeps the slave simple
  assign awready = !r_q.awHeld && !r_q.bv && clkEn;
  assign wready  = !r_q.wHeld && !r_q.bv && clkEn;
  assign arready = !r_q.rv && clkEn;
  assign bvalid  = r_q.bv;
  assign bresp   = r_q.br;
  assign rvalid  = r_q.rv;
  assign rdata   = r_q.rd;
  assign rresp   = r_q.rr;

  // Interrupt request from flags gated by masks
  assign irqReq = (r_q.ctl1[spc_pkg::RX_FAULT_IRQ_EN_BIT]         // RULE_02 RULE_20
                   && (r_q.rxFull || r_q.fault))
                  || (r_q.ctl1[spc_pkg::TX_EMPTY_IRQ_EN_BIT]      // RULE_04
                   && r_q.txEmpty && enabled);

  // Pin drivers; every driver is off while the fault flag is set
  always_comb begin
    pinOut         = '0;
    pinOut.clkOut  = r_q.sck ^ clock_polarity;                            // RULE_06
    pinOut.selOut  = (r_q.st == spc_pkg::ST_IDLE);
    pinOut.mosiOut = r_q.dataOut;
    pinOut.misoOut = r_q.dataOut;
    if (enabled && !r_q.fault) begin
      if (master) begin
        pinOut.clkOe  = 1'b1;                                   // RULE_21
        pinOut.mosiOe = !single || r_q.ctl2[spc_pkg::BIDIR_OUTPUT_EN_BIT];  // RULE_11
        pinOut.selOe  = autoSel;
      end else if (selLow) begin
        pinOut.misoOe = !single || r_q.ctl2[spc_pkg::BIDIR_OUTPUT_EN_BIT];  // RULE_11
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/spc_pkg.sv
// Package: register map, field positions, reset values and carriers of the SPI unit
`default_nettype none
package spc_pkg;
  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] OFF_CONTROL_ONE      = 8'h00;
  localparam logic [7:0] OFF_CONTROL_TWO      = 8'h04;
  localparam logic [7:0] OFF_BIT_RATE_DIVIDER = 8'h08;
  localparam logic [7:0] OFF_FLAG_STATUS      = 8'h0C;
  localparam logic [7:0] OFF_SHIFT_DATA       = 8'h10;
  localparam logic [7:0] OFF_WAIT_CTRL        = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RX_FAULT_IRQ_EN_BIT   = 7;
  localparam int SYSTEM_ENABLE_BIT     = 6;
  localparam int TX_EMPTY_IRQ_EN_BIT   = 5;
  localparam int MASTER_SELECT_BIT     = 4;
  localparam int CLOCK_POLARITY_BIT    = 3;
  localparam int CLOCK_PHASE_BIT       = 2;
  localparam int SELECT_OUTPUT_EN_BIT  = 1;
  localparam int LOW_BIT_FIRST_BIT     = 0;
  localparam int FAULT_DETECT_EN_BIT   = 4;
  localparam int BIDIR_OUTPUT_EN_BIT   = 3;
  localparam int WAIT_CLOCK_STOP_BIT   = 1;
  localparam int SINGLE_WIRE_SEL_BIT   = 0;
  localparam int RX_FULL_FLAG_BIT      = 7;
  localparam int TX_EMPTY_FLAG_BIT     = 5;
  localparam int FAULT_FLAG_BIT        = 4;

  // ****************************************************************
  // Implemented-bit masks and reset values
  // ****************************************************************
  localparam logic [7:0] CONTROL_TWO_MASK = 8'h1B;
  localparam logic [7:0] BIT_RATE_MASK    = 8'h77;
  localparam logic [7:0] CONTROL_ONE_RST  = 8'h04;
  localparam logic [7:0] CONTROL_TWO_RST  = 8'h00;
  localparam logic [7:0] BIT_RATE_RST     = 8'h00;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;
  localparam int         BITS_PER_BYTE    = 8;

  // Transfer engine states, Gray along idle-lead-run-trail
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_RUN   = 2'b11,
    ST_TRAIL = 2'b10
  } spc_state_type;

  // Serial pins: inputs
  typedef struct packed {
    logic clkIn;
    logic mosiIn;
    logic misoIn;
    logic selIn;
  } spc_pin_in_type;

  // Serial pins: outputs and enables
  typedef struct packed {
    logic clkOut;
    logic clkOe;
    logic mosiOut;
    logic mosiOe;
    logic misoOut;
    logic misoOe;
    logic selOut;
    logic selOe;
  } spc_pin_out_type;
endpackage
`default_nettype wire

// >>> test/spc_unit_assertions.sv
// Checker: bus handshake and serial frame properties
`default_nettype none
module spc_unit_assertions (
  input wire logic                     mclk,
  input wire logic                     nrst,
  input wire logic                     clkEn,
  input wire logic                     awvalid,
  input wire logic                     awready,
  input wire logic                     wvalid,
  input wire logic                     wready,
  input wire logic                     bvalid,
  input wire logic                     bready,
  input wire logic                     arvalid,
  input wire logic                     arready,
  input wire logic                     rvalid,
  input wire logic                     rready,
  input wire logic [31:0]              rdata,
  input wire spc_pkg::spc_pin_out_type pinOut
);
  // ****************
  // Helper logic
  // ****************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  logic       clkPrev_q;
  logic [4:0] edgeCnt_q;

  // Clock edges per frame
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clkPrev_q <= 1'b0;
      edgeCnt_q <= 5'h00;
    end else begin
      clkPrev_q <= pinOut.clkOut;
      if (pinOut.selOut) edgeCnt_q <= 5'h00;
      else if (pinOut.clkOut != clkPrev_q) edgeCnt_q <= edgeCnt_q + 5'h01;
    end
  end

  sequence writeTaken;
    awvalid && awready && wvalid && wready && clkEn;
  endsequence

  // ****************
  // Properties
  // ****************
  a_write_answer: assert property (writeTaken |-> ##[1:2] bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready && clkEn |=> rvalid)
    else $error("read response late");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
  a_write_once: assert property (bvalid && bready && clkEn |=> !bvalid)
    else $error("write response repeated");
  a_read_once: assert property (rvalid && rready && clkEn |=> !rvalid)
    else $error("read response repeated");
  a_write_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  a_read_refuse: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
  a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_frame_edges: assert property ($rose(pinOut.selOut) && pinOut.clkOe
    |-> edgeCnt_q == 5'h10)
    else $error("frame without sixteen clock edges");
endmodule
`default_nettype wire

// >>> test/spc_serial_peer.sv
// Behavioural serial peripheral facing the unit when it is master
`default_nettype none
module spc_serial_peer (
  input  wire logic       sclk,
  input  wire logic       sel,
  input  wire logic       mosi,
  input  wire logic       clock_phase,
  input  wire logic       lsbFirst,
  input  wire logic [7:0] txByte,
  output var  logic       miso,
  output var  logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ps;
  int         edges = 0;
  int         bitNum = 0;
  logic [7:0] rxSh = 8'h00;
  function automatic logic pick(input logic [2:0] n);
    return lsbFirst ? txByte[n] : txByte[3'h7 - n];
  endfunction
  initial miso = 1'b0;
  initial rxByte = 8'h00;
  // Phase 0 drives the first bit at select
  always @(negedge sel) begin
    edges = 0;
    bitNum = 0;
    if (!clock_phase) miso = pick(3'h0);
  end
  // Released line shows the inverse
  always @(posedge sel) begin
    rxByte = rxSh;
    miso = ~miso;
  end
  // Odd or even edges sample, the others shift
  always @(sclk) if (!sel) begin
    edges++;
    if (clock_phase ? (edges % 2 == 0) : (edges % 2 == 1)) begin
      rxSh = lsbFirst ? {mosi, rxSh[7:1]} : {rxSh[6:0], mosi};
    end else begin
      if (!(clock_phase && edges == 1)) bitNum++;
      miso = (bitNum < 8) ? pick(bitNum[2:0]) : ~miso;
    end
  end
endmodule
`default_nettype wire

// >>> test/spi_config_and_status_tb.sv
// Testbench: registers, transfers, fault and pin enables
`default_nettype none
module spi_config_and_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     mclk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic                     awready, wready, bvalid, arready, rvalid, irqReq;
  logic                     peerMiso, selDrv, clock_phase, lsbFirst, cpuWait;
  logic [7:0]               awaddr, araddr, peerTx, peerRx;
  logic [31:0]              wdata, rdata;
  logic [1:0]               bresp, rresp, lastResp;
  spc_pkg::spc_pin_in_type  pinIn;
  spc_pkg::spc_pin_out_type pinOut;
  int                       failures = 0;
  int                       samples_checked = 0;

  // Undriven clock and MOSI lines show the inverse; MISO and select come from peerMiso and selDrv
  assign pinIn = '{clkIn: pinOut.clkOe ? pinOut.clkOut : ~pinOut.clkOut,
                   mosiIn: pinOut.mosiOe ? pinOut.mosiOut : ~pinOut.mosiOut,
                   misoIn: pinOut.misoOe ? pinOut.misoOut : peerMiso,
                   selIn: pinOut.selOe ? pinOut.selOut : selDrv};

  spc_unit i_dut (.mclk(mclk), .nrst(nrst), .clkEn(1'b1), .cpuWait(cpuWait),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .pinIn(pinIn), .pinOut(pinOut), .irqReq(irqReq));
  spc_serial_peer i_peer (.sclk(pinOut.clkOut), .sel(pinOut.selOut), .mosi(pinOut.mosiOut),
    .clock_phase(clock_phase), .lsbFirst(lsbFirst), .txByte(peerTx), .miso(peerMiso), .rxByte(peerRx));

  // ****************
  // Shared tasks
  // ****************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("Counts: %0d checked, %0d failed", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Address and data together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    lastResp = bresp;
  endtask
  // Ready raised late to exercise held data
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b1;
    @(posedge mclk);
    rready <= 1'b0;
    chk(rdata, exp);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic regReset;
    rd(spc_pkg::OFF_CONTROL_ONE, 32'h4);
    rd(spc_pkg::OFF_FLAG_STATUS, 32'h20);
    wr(spc_pkg::OFF_CONTROL_TWO, 8'hFF);
    rd(spc_pkg::OFF_CONTROL_TWO, 32'h1B);
    wr(spc_pkg::OFF_BIT_RATE_DIVIDER, 8'hFF);
    rd(spc_pkg::OFF_BIT_RATE_DIVIDER, 32'h77);
    wr(spc_pkg::OFF_FLAG_STATUS, 8'hFF);
    rd(spc_pkg::OFF_FLAG_STATUS, 32'h20);
    wr(8'h18, 8'hFF);
    chk(lastResp, spc_pkg::RESP_SLVERR);
    $display("map test done");
  endtask
  task automatic initXfer;
    clock_phase <= 1'b1;
    peerTx <= 8'hC3;
    wr(spc_pkg::OFF_CONTROL_ONE, 8'h74);
    wr(spc_pkg::OFF_CONTROL_TWO, 8'h00);
    wr(spc_pkg::OFF_BIT_RATE_DIVIDER, 8'h00);
    chk(irqReq, 1'b1);
    wr(spc_pkg::OFF_SHIFT_DATA, 8'hA5);
    wr(spc_pkg::OFF_SHIFT_DATA, 8'h5A);
    rd(spc_pkg::OFF_FLAG_STATUS, 32'h00);
    chk(irqReq, 1'b0);
    @(posedge pinOut.selOut);
    @(posedge mclk);
    chk(peerRx, 8'hA5);
    rd(spc_pkg::OFF_FLAG_STATUS, 32'hA0);
    rd(spc_pkg::OFF_SHIFT_DATA, 32'hC3);
    repeat (30) @(posedge mclk);
    chk(peerRx, 8'h5A);
    wr(spc_pkg::OFF_CONTROL_ONE, 8'h54);
    chk(irqReq, 1'b0);
    wr(spc_pkg::OFF_CONTROL_ONE, 8'hD4);
    chk(irqReq, 1'b1);
    wr(spc_pkg::OFF_CONTROL_ONE, 8'h14);
    rd(spc_pkg::OFF_FLAG_STATUS, 32'h20);
    $display("buffer test done");
  endtask
  // All four formats, one byte each way
  task automatic modes;
    for (int i = 0; i < 4; i++) begin
      clock_phase <= i[0];
      lsbFirst <= i[1];
      peerTx <= 8'h30 + i[7:0];
      wr(spc_pkg::OFF_CONTROL_ONE, 8'h50 | {4'h0, i[1], i[0], 1'b0, i[1]});
      wr(spc_pkg::OFF_SHIFT_DATA, 8'h1D + i[7:0]);
      repeat (30) @(posedge mclk);
      chk(peerRx, 8'h1D + i[7:0]);
      chk(pinOut.clkOut, i[1]);
      rd(spc_pkg::OFF_SHIFT_DATA, 32'h30 + i);
    end
    $display("format test done");
  endtask
  task automatic fault;
    wr(spc_pkg::OFF_CONTROL_TWO, 8'h10);
    wr(spc_pkg::OFF_CONTROL_ONE, 8'hD0);
    selDrv <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(irqReq, 1'b1);
    chk({pinOut.clkOe, pinOut.mosiOe}, 2'h0);
    selDrv <= 1'b1;
    rd(spc_pkg::OFF_CONTROL_ONE, 32'hC0);
    wr(spc_pkg::OFF_CONTROL_ONE, 8'hC0);
    rd(spc_pkg::OFF_FLAG_STATUS, 32'h30);
    wr(spc_pkg::OFF_CONTROL_ONE, 8'h40);
    rd(spc_pkg::OFF_FLAG_STATUS, 32'h20);
    $display("fault test done");
  endtask
  task automatic pins;
    wr(spc_pkg::OFF_CONTROL_ONE, 8'h50);
    wr(spc_pkg::OFF_CONTROL_TWO, 8'h01);
    chk(pinOut.mosiOe, 1'b0);
    wr(spc_pkg::OFF_CONTROL_TWO, 8'h09);
    chk(pinOut.mosiOe, 1'b1);
    wr(spc_pkg::OFF_CONTROL_TWO, 8'h00);
    chk(pinOut.mosiOe, 1'b1);
    wr(spc_pkg::OFF_CONTROL_TWO, 8'h02);
    cpuWait <= 1'b1;
    wr(spc_pkg::OFF_SHIFT_DATA, 8'h11);
    rd(spc_pkg::OFF_FLAG_STATUS, 32'h00);
    cpuWait <= 1'b0;
    repeat (30) @(posedge mclk);
    rd(spc_pkg::OFF_FLAG_STATUS, 32'hA0);
    wr(spc_pkg::OFF_CONTROL_ONE, 8'h40);
    chk({pinOut.clkOe, pinOut.mosiOe}, 2'h0);
    $display("pin test done");
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    conclude();
  end
  initial begin
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, peerTx} = 24'h000000;
    wdata = 32'h00000000;
    {cpuWait, selDrv, clock_phase, lsbFirst} = 4'h4;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    regReset();
    initXfer();
    modes();
    fault();
    pins();
    conclude();
  end
endmodule

bind spc_unit spc_unit_assertions i_chk (.mclk(mclk), .nrst(nrst), .clkEn(clkEn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .pinOut(pinOut));
`default_nettype wire
